// File: smdac_consts.svh
// Constants for the supply margin converter control block.
`ifndef SMDAC_CONSTS_SVH
`define SMDAC_CONSTS_SVH
// ----------------------------------------
// Register map (word index on the plain register port)
// ----------------------------------------
`define SMDAC_OFF_CODE      4'h0
`define SMDAC_OFF_UPPER     4'h1
`define SMDAC_OFF_LOWER     4'h2
`define SMDAC_OFF_CTRL      4'h3
`define SMDAC_OFF_STATUS    4'h4
`define SMDAC_OFF_EFFECTIVE 4'h5
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define SMDAC_CTRL_EN_BIT   0
`define SMDAC_CTRL_RANGE_LO 1
`define SMDAC_CTRL_RANGE_HI 2
`define SMDAC_MIDCODE       8'h7F
`define SMDAC_CODE_RST      8'h7F
`define SMDAC_UPPER_RST     8'hFF
`define SMDAC_LOWER_RST     8'h00
// ----------------------------------------
// Timing: buffer settle time while it follows the pin
// ----------------------------------------
`define SMDAC_SETTLE_NS     1000
`define SMDAC_CLK_NS        10
`define SMDAC_SETTLE_CYC    ((`SMDAC_SETTLE_NS + `SMDAC_CLK_NS - 1) / `SMDAC_CLK_NS)
`endif

// File: smdac_pkg.sv
// Types for the supply margin converter control block.
package smdac_pkg;
   // Output buffer power-up sequence.
   typedef enum logic [1:0] {
      SMDAC_OFF,
      SMDAC_FOLLOW,
      SMDAC_DRIVE
   } smdac_seq_e;
endpackage

// File: smdac_channel.sv
// One margin converter channel: limit clamp and glitch-free buffer enable.
`timescale 1ns/1ps
`include "smdac_consts.svh"
module smdac_channel #(
   parameter int CODE_W = 8,
   parameter int SETTLE_CYC = `SMDAC_SETTLE_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Settings
   input wire logic [CODE_W-1:0] margin_code,
   input wire logic [CODE_W-1:0] upper_code_limit,
   input wire logic [CODE_W-1:0] lower_code_limit,
   input wire logic enable,
   // Converter side
   output logic [CODE_W-1:0] eff_code,
   output logic limits_bad,
   output logic buf_power,
   output logic buf_src_dac,
   output logic buf_drive
);
   smdac_pkg::smdac_seq_e state_reg;
   logic [15:0] settle_reg;
   logic bad;
   logic [CODE_W-1:0] clamp;

   // Clamp selection and inverted-limit check.
   always_comb begin
      bad = (lower_code_limit > upper_code_limit);
      if (margin_code < lower_code_limit) begin
         clamp = lower_code_limit;
      end else if (margin_code > upper_code_limit) begin
         clamp = upper_code_limit;
      end else begin
         clamp = margin_code;
      end
   end

   // Registered clamp result, refreshed the cycle after any settings change.
   always_ff @(posedge clk) begin
      if (rst) begin
         eff_code <= CODE_W'(`SMDAC_MIDCODE);
         limits_bad <= 1'b0;
      end else begin
         eff_code <= clamp;
         limits_bad <= bad;
      end
   end

   // Buffer follows the pin first, then switches to the converter and drives.
   // Inverted limits drop the buffer at once, whatever the enable says.
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= smdac_pkg::SMDAC_OFF;
         settle_reg <= 16'h0000;
      end else if (!enable || bad) begin
         state_reg <= smdac_pkg::SMDAC_OFF;
         settle_reg <= 16'h0000;
      end else begin
         case (state_reg)
            smdac_pkg::SMDAC_OFF: begin
               state_reg <= smdac_pkg::SMDAC_FOLLOW;
               settle_reg <= 16'h0000;
            end
            smdac_pkg::SMDAC_FOLLOW: begin
               if (settle_reg == 16'(SETTLE_CYC - 1)) begin
                  state_reg <= smdac_pkg::SMDAC_DRIVE;
               end else begin
                  settle_reg <= settle_reg + 16'h0001;
               end
            end
            smdac_pkg::SMDAC_DRIVE: begin
               state_reg <= smdac_pkg::SMDAC_DRIVE;
            end
            default: begin
               state_reg <= smdac_pkg::SMDAC_OFF;
            end
         endcase
      end
   end

   // Sequence outputs.
   assign buf_power = (state_reg != smdac_pkg::SMDAC_OFF);
   assign buf_src_dac = (state_reg == smdac_pkg::SMDAC_DRIVE);
   assign buf_drive = (state_reg == smdac_pkg::SMDAC_DRIVE);
endmodule // smdac_channel

// File: smdac_top.sv
// Control logic for six margining voltage-output converters.
// What this block does
// - Six independent channels, each with code, range, enable and two limits.
// - Four offset ranges per channel, code 0x7F sits at the range centre.
// - Margin code is unsigned binary; output voltage is linear in it.
// - Output equals centre plus code distance from midcode times 0.6015/255 volts.
// - Effective code is margin code clamped between lower and upper limits.
// - Lower limit above upper limit forces that buffer to high impedance.
// - All limits are reloaded from nonvolatile memory during startup download.
// - Enable first powers buffer following the pin, then switches and drives.
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "smdac_consts.svh"
module smdac_top #(
   parameter int CHANNELS = 6,
   parameter int CODE_W = 8,
   parameter int SETTLE_CYC = `SMDAC_SETTLE_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port: addr[6:4] channel, addr[3:0] register
   input wire logic [6:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Startup download of limits from nonvolatile memory
   input wire logic nvm_load,
   input wire logic [2:0] nvm_chan,
   input wire logic [CODE_W-1:0] nvm_upper,
   input wire logic [CODE_W-1:0] nvm_lower,
   // Converter controls, one field per channel
   output logic [CHANNELS*CODE_W-1:0] dac_code,
   output logic [CHANNELS*2-1:0] dac_range,
   output logic [CHANNELS-1:0] buf_power,
   output logic [CHANNELS-1:0] buf_src_dac,
   output logic [CHANNELS-1:0] buf_drive
);
   // ----------------------------------------
   // Per-channel settings
   // ----------------------------------------
   logic [CODE_W-1:0] margin_code_reg [CHANNELS];
   logic [CODE_W-1:0] upper_code_limit_reg [CHANNELS];
   logic [CODE_W-1:0] lower_code_limit_reg [CHANNELS];
   logic [CHANNELS-1:0] enable_reg;
   logic [1:0] range_reg [CHANNELS];
   logic [CODE_W-1:0] eff_code [CHANNELS];
   logic [CHANNELS-1:0] limits_bad;
   logic [2:0] sel;
   logic [3:0] reg_idx;
   logic [7:0] rdata_next;

   assign sel = reg_addr[6:4];
   assign reg_idx = reg_addr[3:0];

   // ----------------------------------------
   // Register writes and nonvolatile limit restore
   // ----------------------------------------
   // The download takes priority over a software write to the same limit,
   // since a startup restore must not be half overwritten.
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < CHANNELS; i++) begin
            margin_code_reg[i] <= CODE_W'(`SMDAC_CODE_RST);
            upper_code_limit_reg[i] <= CODE_W'(`SMDAC_UPPER_RST);
            lower_code_limit_reg[i] <= CODE_W'(`SMDAC_LOWER_RST);
            range_reg[i] <= 2'h0;
         end
         enable_reg <= '0;
      end else begin
         for (int i = 0; i < CHANNELS; i++) begin
            if (reg_wr && sel == 3'(i)) begin
               case (reg_idx)
                  `SMDAC_OFF_CODE: margin_code_reg[i] <= reg_wdata[CODE_W-1:0];
                  `SMDAC_OFF_UPPER: upper_code_limit_reg[i] <= reg_wdata[CODE_W-1:0];
                  `SMDAC_OFF_LOWER: lower_code_limit_reg[i] <= reg_wdata[CODE_W-1:0];
                  `SMDAC_OFF_CTRL: begin
                     enable_reg[i] <= reg_wdata[`SMDAC_CTRL_EN_BIT];
                     range_reg[i] <= reg_wdata[`SMDAC_CTRL_RANGE_HI:`SMDAC_CTRL_RANGE_LO];
                  end
                  default: begin
                  end
               endcase
            end
            if (nvm_load && nvm_chan == 3'(i)) begin
               upper_code_limit_reg[i] <= nvm_upper;
               lower_code_limit_reg[i] <= nvm_lower;
            end
         end
      end
   end

   // ----------------------------------------
   // Channels
   // ----------------------------------------
   for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
      smdac_channel #(
         .CODE_W(CODE_W),
         .SETTLE_CYC(SETTLE_CYC)
      ) u_chan (
         .clk(clk),
         .rst(rst),
         .margin_code(margin_code_reg[g]),
         .upper_code_limit(upper_code_limit_reg[g]),
         .lower_code_limit(lower_code_limit_reg[g]),
         .enable(enable_reg[g]),
         .eff_code(eff_code[g]),
         .limits_bad(limits_bad[g]),
         .buf_power(buf_power[g]),
         .buf_src_dac(buf_src_dac[g]),
         .buf_drive(buf_drive[g])
      );
      // The analog stage maps code c to centre + (c - 0x7F) * 0.6015 / 255 V.
      assign dac_code[g*CODE_W +: CODE_W] = eff_code[g];
      assign dac_range[g*2 +: 2] = range_reg[g];
   end

   // ----------------------------------------
   // Register reads
   // ----------------------------------------
   // Unmapped channels and offsets read as zero.
   always_comb begin
      rdata_next = 8'h00;
      for (int i = 0; i < CHANNELS; i++) begin
         if (sel == 3'(i)) begin
            case (reg_idx)
               `SMDAC_OFF_CODE: rdata_next = 8'(margin_code_reg[i]);
               `SMDAC_OFF_UPPER: rdata_next = 8'(upper_code_limit_reg[i]);
               `SMDAC_OFF_LOWER: rdata_next = 8'(lower_code_limit_reg[i]);
               `SMDAC_OFF_CTRL: rdata_next = {5'h00, range_reg[i], enable_reg[i]};
               `SMDAC_OFF_STATUS: rdata_next = {5'h00, buf_drive[i], buf_power[i],
                                                limits_bad[i]};
               `SMDAC_OFF_EFFECTIVE: rdata_next = 8'(eff_code[i]);
               default: rdata_next = 8'h00;
            endcase
         end
      end
   end

   // Read data stand only in the cycle after the read strobe.
   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rdata_next;
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule // smdac_top

// File: smdac_top_asserts.sv
// Checker for the supply margin converter control block.
`timescale 1ns/1ps
`include "smdac_consts.svh"
module smdac_top_asserts #(
   parameter int CHANNELS = 6,
   parameter int CODE_W = 8,
   parameter int SETTLE_CYC = `SMDAC_SETTLE_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire logic [6:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Limit restore
   input wire logic nvm_load,
   input wire logic [2:0] nvm_chan,
   input wire logic [CODE_W-1:0] nvm_upper,
   input wire logic [CODE_W-1:0] nvm_lower,
   // Converter controls
   input wire logic [CHANNELS*CODE_W-1:0] dac_code,
   input wire logic [CHANNELS*2-1:0] dac_range,
   input wire logic [CHANNELS-1:0] buf_power,
   input wire logic [CHANNELS-1:0] buf_src_dac,
   input wire logic [CHANNELS-1:0] buf_drive
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   // One clock domain, so clock and reset are given once.
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_rd_only; reg_rdata != 8'h00 |-> $past(reg_rd); endproperty
   a_rd_only: assert property (p_rd_only) else $error("read data outside slot");
   property p_bad_chan; reg_rd && reg_addr[6:4] > 3'h5 |=> reg_rdata == 8'h00; endproperty
   a_bad_chan: assert property (p_bad_chan) else $error("unmapped read not zero");
   property p_pair; buf_drive == buf_src_dac; endproperty
   a_pair: assert property (p_pair) else $error("switch and drive apart");
   property p_pow; (buf_drive & ~buf_power) == '0; endproperty
   a_pow: assert property (p_pow) else $error("drive without power");
   property p_follow;
      ((buf_drive & ~$past(buf_drive)) & ~$past(buf_power, SETTLE_CYC)) == '0;
   endproperty
   a_follow: assert property (p_follow) else $error("drive before follow time");
   property p_off;
      reg_wr && reg_addr == 7'h13 && !reg_wdata[0] ##1 !(reg_wr && reg_addr == 7'h13)
      |=> !buf_power[1];
   endproperty
   a_off: assert property (p_off) else $error("buffer kept on");
   property p_tri; reg_rd && reg_addr == 7'h14 ##1 reg_rdata[0] |-> !buf_drive[1]; endproperty
   a_tri: assert property (p_tri) else $error("bad limits still drive");
   property p_rst; $fell(rst) |-> dac_code == {CHANNELS{8'h7F}} && buf_power == '0; endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
   // Main scenarios reached.
   c_drive: cover property ($rose(buf_drive[1]));
   c_unmap: cover property (reg_rd && reg_addr == 7'h61);
   c_nvm: cover property (nvm_load);
endmodule // smdac_top_asserts
bind smdac_top smdac_top_asserts #(.CHANNELS(CHANNELS), .CODE_W(CODE_W),
   .SETTLE_CYC(SETTLE_CYC)) u_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .nvm_load(nvm_load), .nvm_chan(nvm_chan), .nvm_upper(nvm_upper), .nvm_lower(nvm_lower),
   .dac_code(dac_code), .dac_range(dac_range), .buf_power(buf_power),
   .buf_src_dac(buf_src_dac), .buf_drive(buf_drive));

// File: smdac_fb_model.sv
// Feedback node model: level seen at each converter pin.
`timescale 1ns/1ps
module smdac_fb_model (
   // Clock and converter controls
   input wire logic clk,
   input wire logic [47:0] dac_code,
   input wire logic [5:0] buf_drive,
   // Level at the pins
   output logic [47:0] pin_level
);
   initial pin_level = 48'h0;
   // An undriven pin floats, so it flips every cycle rather than hold a stale code.
   always @(posedge clk) begin
      for (int n = 0; n < 6; n++) begin
         pin_level[n*8+:8] <= buf_drive[n] ? dac_code[n*8+:8] : ~pin_level[n*8+:8];
      end
   end
endmodule // smdac_fb_model

// File: smdac_top_tb_top.sv
// Testbench for the supply margin converter control block.
`timescale 1ns/1ps
module smdac_top_tb_top;
   logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, nvm_load = 1'b0, rd_d = 1'b0;
   logic [6:0] reg_addr = 7'h00;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, nvm_upper = 8'h00, nvm_lower = 8'h00;
   logic [2:0] nvm_chan = 3'h0;
   logic [47:0] dac_code, pin_level;
   logic [11:0] dac_range;
   logic [5:0] buf_power, buf_src_dac, buf_drive;
   logic [31:0] seed = 32'h343D;
   logic [7:0] cin [5] = '{8'h90, 8'hC0, 8'h10, 8'hA0, 8'h40};
   logic [7:0] cex [5] = '{8'h90, 8'hA0, 8'h40, 8'hA0, 8'h40};
   logic [7:0] exp_q [$];
   int fail_count = 0, comparisons = 0;
   smdac_top #(.SETTLE_CYC(4)) DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .nvm_load(nvm_load), .nvm_chan(nvm_chan), .nvm_upper(nvm_upper),
      .nvm_lower(nvm_lower), .dac_code(dac_code), .dac_range(dac_range),
      .buf_power(buf_power), .buf_src_dac(buf_src_dac), .buf_drive(buf_drive));
   smdac_fb_model u_fb (.clk(clk), .dac_code(dac_code), .buf_drive(buf_drive),
      .pin_level(pin_level));
   // 100 MHz clock.
   initial forever #5 clk = ~clk;
   task automatic chk(input logic [7:0] seen, input logic [7:0] want);
      comparisons++;
      if (seen !== want) begin
         fail_count++;
         $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
      end
   endtask
   task automatic complete_run;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Random stimulus source, one shift per call.
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Strobes stay up between back-to-back calls; idle lowers them.
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] want);
      exp_q.push_back(want);
      reg_rd <= 1'b1;
      reg_wr <= 1'b0;
      reg_addr <= a;
      @(posedge clk);
   endtask
   task automatic idle(input int n);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (n) @(posedge clk);
   endtask
   // Read data stands only in the cycle after the strobe.
   always @(posedge clk) begin
      if (rd_d) chk(reg_rdata, exp_q.pop_front());
      rd_d <= reg_rd;
   end
   // A hang is cut short well past the expected run of under 600 cycles.
   initial begin
      #50000;
      fail_count++;
      complete_run();
   end
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk(dac_code[15:8], 8'h7F);
      rd(7'h10, 8'h7F);
      rd(7'h11, 8'hFF);
      rd(7'h12, 8'h00);
      rd(7'h13, 8'h00);
      wr(7'h13, 8'h00);
      wr(7'h11, 8'hA0);
      wr(7'h12, 8'h40);
      for (int i = 0; i < 5; i++) begin
         wr(7'h10, cin[i]);
         idle(2);
         chk(dac_code[15:8], cex[i]);
         rd(7'h15, cex[i]);
      end
      wr(7'h13, 8'h07);
      idle(3);
      chk({5'h00, buf_power[1], buf_src_dac[1], buf_drive[1]}, 8'h04);
      idle(5);
      chk({5'h00, buf_power[1], buf_src_dac[1], buf_drive[1]}, 8'h07);
      chk({6'h0, dac_range[3:2]}, 8'h03);
      chk(pin_level[15:8], 8'h40);
      rd(7'h14, 8'h06);
      for (int r = 0; r < 4; r++) begin
         wr(7'h33, 8'(r * 2));
         idle(2);
         chk({6'h0, dac_range[7:6]}, 8'(r));
      end
      // Host steps the code until the pin reaches its target.
      for (int i = 0; i < 32 && pin_level[15:8] !== 8'h50; i++) begin
         wr(7'h10, 8'h41 + 8'(i));
         idle(3);
      end
      chk(pin_level[15:8], 8'h50);
      wr(7'h12, 8'hB0);
      idle(2);
      chk({7'h0, buf_drive[1]}, 8'h00);
      rd(7'h14, 8'h01);
      // Drop the read strobe so the restore cycle carries no unrecorded read.
      idle(0);
      nvm_load <= 1'b1;
      nvm_chan <= 3'h2;
      nvm_upper <= 8'h50;
      nvm_lower <= 8'h30;
      @(posedge clk);
      nvm_load <= 1'b0;
      rd(7'h21, 8'h50);
      rd(7'h22, 8'h30);
      wr(7'h61, 8'h12);
      rd(7'h61, 8'h00);
      rd(7'h07, 8'h00);
      repeat (16) begin
         seed = lfsr_next(seed);
         wr(7'h00, seed[7:0]);
         idle(1);
         rd(7'h05, seed[7:0]);
      end
      // A reset in mid-run must drop a driving buffer and restore the codes.
      wr(7'h03, 8'h01);
      idle(8);
      chk({7'h00, buf_drive[0]}, 8'h01);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk(dac_code[7:0], 8'h7F);
      chk({2'h0, buf_power}, 8'h00);
      rd(7'h03, 8'h00);
      idle(3);
      complete_run();
   end
endmodule // smdac_top_tb_top
